// ### shared/rx_deskew_pkg.sv
package rx_deskew_pkg;
    // phase steps per vco period (one step is 1/56 of the vco period)
    localparam int unsigned STEPS_PER_VCO_PERIOD = 56;
    // default number of phase steps the integrator requests
    localparam int unsigned SHIFT_COUNT_DEFAULT = 28;
    // default channel count of the link
    localparam int unsigned LANE_COUNT_DEFAULT = 4;
    // width of the step counter
    localparam int unsigned STEP_CNT_W = 16;
    // clock rate and fifo-clear pulse length
    localparam int unsigned SYS_CLK_MHZ = 40;
    localparam int unsigned CLEAR_PULSE_NS = 100;
    localparam int unsigned CLEAR_PULSE_CYC =
        (CLEAR_PULSE_NS * SYS_CLK_MHZ + 999) / 1000;
    // multi-lane master/slave mode default for the four-lane profile
    localparam logic MULTI_LANE_DEFAULT = 1'h1;
    // deskew sequencer states
    typedef enum logic [2:0] {
        DS_IDLE,
        DS_REQ,
        DS_WAIT,
        DS_CLEAR,
        DS_DONE
    } deskew_state_t;
endpackage

// ### rtl/tx_phase_init_seq.sv
`timescale 1ns/1ps
`default_nettype none
// tx phase alignment: master and slave init requests raised together,
// master complete only after every slave complete, in any order
module tx_phase_init_seq #(
    parameter int unsigned LANES = 4
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic             clkEn,
    input  wire logic             startAlign,
    input  wire logic [LANES-1:0] slaveDoneSync,
    output logic                  masterReqQ,
    output logic [LANES-1:0]      slaveReqQ,
    output logic                  masterCompleteQ
);
    logic [LANES-1:0] seenDone_q; // sticky per-slave completion

    // per-lane sticky latches tolerate any arrival order
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    seenDone_q[g] <= 1'h0;
                end else if (clkEn) begin
                    if (startAlign) begin
                        seenDone_q[g] <= 1'h0;
                    end else if (slaveDoneSync[g]) begin
                        seenDone_q[g] <= 1'h1;
                    end
                end
            end
        end
    endgenerate

    // requests: master and slaves share one flop edge
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            masterReqQ <= 1'h0;
            slaveReqQ  <= '0;
        end else if (clkEn) begin
            masterReqQ <= startAlign;
            slaveReqQ  <= {LANES{startAlign}};
        end
    end

    // master complete gated on all slaves
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            masterCompleteQ <= 1'h0;
        end else if (clkEn) begin
            masterCompleteQ <= !startAlign && (&seenDone_q);
        end
    end

    // every slave request stands whenever the master request does
    property p_req_master_slave;
        @(posedge sys_clk) disable iff (!rst_n)
        masterReqQ |-> (&slaveReqQ);
    endproperty
    a_req_master_slave: assert property (p_req_master_slave)
        else $error("slave init request not with master");
    // no slave request stands without the master request
    property p_req_slave_master;
        @(posedge sys_clk) disable iff (!rst_n)
        (|slaveReqQ) |-> masterReqQ;
    endproperty
    a_req_slave_master: assert property (p_req_slave_master)
        else $error("slave init request without master");
    property p_all_slaves;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(masterCompleteQ) |-> $past(&seenDone_q);
    endproperty
    a_all_slaves: assert property (p_all_slaves)
        else $error("master complete before all slaves");
endmodule
`default_nettype wire

// ### rtl/rx_lane_phase_deskew.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - each step is 1/56 of vco period
// - only this fsm shifts clock phase
// - start after all channels report reset-done
// - each rising reset-done while locked restarts the sequence
// - shift the elastic buffer read clock
// - retraining toggles reset-done, rerunning adjustment
// - multi-lane master/slave mode on only with the four-lane profile
// - slave init request with master request
// - master complete only after all slaves
// - slave completes may arrive in any order
// - buffer clear always exposed at top
module rx_lane_phase_deskew #(
    parameter int unsigned LANES       = rx_deskew_pkg::LANE_COUNT_DEFAULT,
    parameter int unsigned SHIFT_COUNT = rx_deskew_pkg::SHIFT_COUNT_DEFAULT
) (
    input  wire logic             sys_clk,       // fabric user clock
    input  wire logic             rst_n,         // async reset, active low
    input  wire logic             clkEn,         // freezes all state when low
    input  wire logic [LANES-1:0] rxResetDone,   // per-channel reset done
    input  wire logic             clkMgrLocked,  // clock manager lock
    input  wire logic             psDone,        // phase-step acknowledge
    input  wire logic             extBufClear,   // external buffer clear
    input  wire logic             multiLaneSel,  // four-lane profile chosen
    input  wire logic             txAlignStart,  // tx phase alignment start
    input  wire logic [LANES-1:0] txPhaseInitComplete, // slave completes
    output logic                  psEnQ,         // phase-step request
    output logic                  psIncDecQ,     // step direction, 1 = later
    output logic                  rxFifoBufferClearQ, // buffer clear
    output logic                  deskewDoneQ,   // adjustment finished
    output logic                  multiLaneModeQ,// master/slave mode
    output logic                  masterTxPhaseInitReqQ,
    output logic [LANES-1:0]      slaveTxPhaseInitReqQ,
    output logic                  masterTxPhaseInitCompleteQ
);
    localparam int unsigned CW = rx_deskew_pkg::STEP_CNT_W;
    localparam logic [CW-1:0] SHIFT_TARGET = CW'(SHIFT_COUNT);
    localparam logic [7:0] CLEAR_LEN = 8'(rx_deskew_pkg::CLEAR_PULSE_CYC);

    // synchroniser stages for pin inputs
    logic [LANES-1:0] doneMeta_q, doneSync_q;  // reset-done per lane
    logic [LANES-1:0] txcMeta_q, txcSync_q;    // tx slave completes
    logic [2:0]       ctlMeta_q, ctlSync_q;    // lock, ps done, ext clear
    logic             allDonePrev_q;           // combined done, delayed
    logic             allDone;                 // combined reset-done
    logic             doneRise;                // rising edge of combined
    logic             lockedS, psDoneS, extClrS;

    rx_deskew_pkg::deskew_state_t state_q;     // sequencer state
    logic [CW-1:0]    stepCnt_q;               // steps acknowledged so far
    logic [7:0]       clrCnt_q;                // clear pulse countdown
    logic             extClr_q;                // registered external clear

    // two-flop synchronisers, first stage read only by the second
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            doneMeta_q <= '0;
            doneSync_q <= '0;
            txcMeta_q  <= '0;
            txcSync_q  <= '0;
            ctlMeta_q  <= 3'h0;
            ctlSync_q  <= 3'h0;
        end else if (clkEn) begin
            doneMeta_q <= rxResetDone;
            doneSync_q <= doneMeta_q;
            txcMeta_q  <= txPhaseInitComplete;
            txcSync_q  <= txcMeta_q;
            ctlMeta_q  <= {extBufClear, psDone, clkMgrLocked};
            ctlSync_q  <= ctlMeta_q;
        end
    end

    assign lockedS = ctlSync_q[0];
    assign psDoneS = ctlSync_q[1];
    assign extClrS = ctlSync_q[2];
    assign allDone  = &doneSync_q;
    assign doneRise = allDone && !allDonePrev_q;

    // edge memory of the combined reset-done
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            allDonePrev_q <= 1'h0;
        end else if (clkEn) begin
            allDonePrev_q <= allDone;
        end
    end

    // deskew sequencer: steps the read-clock phase of the buffer
    // only this fsm raises a step request; the clock manager sees one
    // request at a time unless a reset-done edge restarts the run while a
    // step is pending, and the count moves only on its acknowledge,
    // so a lost or late ack stalls the run rather than skipping a step
    // unlock wins over everything and parks the fsm in idle; a step ack
    // still in flight then lands in idle and is dropped
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= rx_deskew_pkg::DS_IDLE;
            stepCnt_q <= '0;
            psEnQ     <= 1'h0;
        end else if (clkEn) begin
            psEnQ <= 1'h0;
            if (!lockedS) begin
                // unlocked: hold idle, no requests
                state_q   <= rx_deskew_pkg::DS_IDLE;
                stepCnt_q <= '0;
            end else if (doneRise) begin
                // fresh reset-done edge restarts from the start
                state_q   <= rx_deskew_pkg::DS_REQ;
                stepCnt_q <= '0;
            end else begin
                case (state_q)
                    rx_deskew_pkg::DS_IDLE: begin
                        // wait for a rising combined reset-done
                        state_q <= rx_deskew_pkg::DS_IDLE;
                    end
                    rx_deskew_pkg::DS_REQ: begin
                        if (stepCnt_q >= SHIFT_TARGET) begin
                            state_q <= rx_deskew_pkg::DS_CLEAR;
                        end else if (allDone) begin
                            psEnQ   <= 1'h1;
                            state_q <= rx_deskew_pkg::DS_WAIT;
                        end else begin
                            state_q <= rx_deskew_pkg::DS_IDLE;
                        end
                    end
                    rx_deskew_pkg::DS_WAIT: begin
                        // one request outstanding until acknowledged
                        if (psDoneS) begin
                            stepCnt_q <= stepCnt_q + CW'(1);
                            state_q   <= rx_deskew_pkg::DS_REQ;
                        end
                    end
                    rx_deskew_pkg::DS_CLEAR: begin
                        if (clrCnt_q == 8'h01) begin
                            state_q <= rx_deskew_pkg::DS_DONE;
                        end
                    end
                    default: begin
                        state_q <= rx_deskew_pkg::DS_DONE;
                    end
                endcase
            end
        end
    end

    // clear countdown, armed on entry to the clear state
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            clrCnt_q <= 8'h00;
        end else if (clkEn) begin
            if (state_q != rx_deskew_pkg::DS_CLEAR) begin
                clrCnt_q <= CLEAR_LEN;
            end else if (clrCnt_q != 8'h00) begin
                clrCnt_q <= clrCnt_q - 8'h01;
            end
        end
    end

    // outputs: buffer clear, completion, direction, mode
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            extClr_q           <= 1'h0;
            rxFifoBufferClearQ <= 1'h0;
            deskewDoneQ        <= 1'h0;
            psIncDecQ          <= 1'h0;
            multiLaneModeQ     <= 1'h0;
        end else if (clkEn) begin
            extClr_q <= extClrS;
            // internal post-adjust clear or external clear, always at top
            rxFifoBufferClearQ <= extClr_q ||
                (state_q == rx_deskew_pkg::DS_CLEAR);
            deskewDoneQ <= (state_q == rx_deskew_pkg::DS_DONE) && lockedS;
            psIncDecQ   <= 1'h1;  // (fixed 1/56 vco step)
            multiLaneModeQ <= multiLaneSel ?
                rx_deskew_pkg::MULTI_LANE_DEFAULT : 1'h0;
        end
    end

    // tx phase-alignment handshake sequencer
    tx_phase_init_seq #(
        .LANES(LANES)
    ) u_tx_phase (
        .sys_clk        (sys_clk),
        .rst_n          (rst_n),
        .clkEn          (clkEn),
        .startAlign     (txAlignStart),
        .slaveDoneSync  (txcSync_q),
        .masterReqQ     (masterTxPhaseInitReqQ),
        .slaveReqQ      (slaveTxPhaseInitReqQ),
        .masterCompleteQ(masterTxPhaseInitCompleteQ)
    );

    // checks
    sequence s_req_issued;
        psEnQ ##1 !psEnQ;
    endsequence
    property p_one_step;
        @(posedge sys_clk) disable iff (!rst_n)
        psEnQ |-> ##1 (!psEnQ throughout (state_q == rx_deskew_pkg::DS_WAIT));
    endproperty
    a_one_step: assert property (p_one_step)
        else $error("second step before acknowledge");
    property p_unlocked_quiet;
        @(posedge sys_clk) disable iff (!rst_n)
        (!lockedS && clkEn) |=> !psEnQ;
    endproperty
    a_unlocked_quiet: assert property (p_unlocked_quiet)
        else $error("phase step while unlocked");
    property p_start_all_done;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(psEnQ) |-> $past(allDone);
    endproperty
    a_start_all_done: assert property (p_start_all_done)
        else $error("shift without all reset-done");
    property p_restart;
        @(posedge sys_clk) disable iff (!rst_n)
        (doneRise && lockedS && clkEn) |=>
            (state_q == rx_deskew_pkg::DS_REQ && stepCnt_q == '0);
    endproperty
    a_restart: assert property (p_restart)
        else $error("reset-done edge did not restart");
    property p_count_limit;
        @(posedge sys_clk) disable iff (!rst_n)
        psEnQ |-> ($past(stepCnt_q) < SHIFT_TARGET);
    endproperty
    a_count_limit: assert property (p_count_limit)
        else $error("step beyond configured count");
    property p_clear_after;
        @(posedge sys_clk) disable iff (!rst_n)
        (state_q == rx_deskew_pkg::DS_CLEAR && clkEn) |=> rxFifoBufferClearQ;
    endproperty
    a_clear_after: assert property (p_clear_after)
        else $error("buffer clear missing after adjust");
    property p_step_req;
        @(posedge sys_clk) disable iff (!rst_n)
        s_req_issued |-> psIncDecQ;
    endproperty
    a_step_req: assert property (p_step_req)
        else $error("step issued without direction");
    property p_mode;
        @(posedge sys_clk) disable iff (!rst_n)
        (multiLaneSel && clkEn) |=> multiLaneModeQ;
    endproperty
    a_mode: assert property (p_mode)
        else $error("multi-lane mode not set");

    // sequencer checks beyond the basic step handshake
    // a step request can only come out of the request state
    property p_req_from_fsm;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(psEnQ) |-> ($past(state_q) == rx_deskew_pkg::DS_REQ);
    endproperty
    a_req_from_fsm: assert property (p_req_from_fsm)
        else $error("step request outside the request state");

    // idle issues no step requests
    property p_idle_quiet;
        @(posedge sys_clk) disable iff (!rst_n)
        (state_q == rx_deskew_pkg::DS_IDLE && clkEn) |=> !psEnQ;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("step request from idle");

    // completion is only reported while the clock manager is locked
    property p_done_locked;
        @(posedge sys_clk) disable iff (!rst_n)
        deskewDoneQ |-> $past(lockedS);
    endproperty
    a_done_locked: assert property (p_done_locked)
        else $error("adjustment done while unlocked");

    // an external clear request reaches the buffer clear output
    property p_ext_clear;
        @(posedge sys_clk) disable iff (!rst_n)
        (extClr_q && clkEn) |=> rxFifoBufferClearQ;
    endproperty
    a_ext_clear: assert property (p_ext_clear)
        else $error("external buffer clear not passed on");

    // issued steps never pass the configured count
    property p_count_cap;
        @(posedge sys_clk) disable iff (!rst_n)
        (stepCnt_q <= SHIFT_TARGET);
    endproperty
    a_count_cap: assert property (p_count_cap)
        else $error("step count above target");

    // no step requests while the buffer is being cleared
    property p_clear_quiet;
        @(posedge sys_clk) disable iff (!rst_n)
        (state_q == rx_deskew_pkg::DS_CLEAR) |-> !psEnQ;
    endproperty
    a_clear_quiet: assert property (p_clear_quiet)
        else $error("step request during buffer clear");

    // clear still stands as the sequencer moves on to done
    sequence s_clear_to_done;
        (state_q == rx_deskew_pkg::DS_CLEAR) ##1
            (state_q == rx_deskew_pkg::DS_DONE);
    endsequence
    property p_clear_to_done;
        @(posedge sys_clk) disable iff (!rst_n)
        s_clear_to_done |-> rxFifoBufferClearQ;
    endproperty
    a_clear_to_done: assert property (p_clear_to_done)
        else $error("done reached without buffer clear");
endmodule
`default_nettype wire

// ### testbench/phase_step_model.sv
`timescale 1ns/1ps
`default_nettype none
// clock manager phase-shift port: one acknowledge per step request; a request while busy restarts the wait and shares one
module phase_step_model (
    input  wire logic sys_clk,    // fabric clock
    input  wire logic rst_n,      // async reset, active low
    input  wire logic slowAck,    // long acknowledge delay when high
    input  wire logic psEn,       // step request
    output logic      psDone,     // one-cycle acknowledge
    output logic      overlapErr  // request while a step was pending
);
    logic [3:0] waitQ;  // cycles left before the acknowledge
    logic       busyQ;  // a step is in flight
    // accept a request, then answer after a short or long delay
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            waitQ      <= 4'h0;
            busyQ      <= 1'b0;
            psDone     <= 1'b0;
            overlapErr <= 1'b0;
        end else begin
            psDone <= 1'b0;
            if (psEn) begin
                overlapErr <= overlapErr | busyQ;
                busyQ      <= 1'b1;
                waitQ      <= slowAck ? 4'h6 : 4'h1;
            end else if (busyQ && waitQ == 4'h0) begin
                psDone <= 1'b1;
                busyQ  <= 1'b0;
            end else if (busyQ) begin
                waitQ <= waitQ - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ### testbench/test_rx_lane_phase_deskew.sv
`timescale 1ns/1ps
`default_nettype none
module test_rx_lane_phase_deskew;
    localparam int unsigned LANES = 4;
    localparam int unsigned STEPS = 3;  // short step count for simulation
    logic             sys_clk, rst_n, clkMgrLocked, psDone, extBufClear;
    logic             multiLaneSel, txAlignStart, slowAck, overlapErr, clkEn;
    logic [LANES-1:0] rxResetDone, txPhaseInitComplete, slaveReq;
    logic             psEnQ, psIncDecQ, clearQ, doneQ, modeQ;
    logic             masterReq, masterCmp;
    int               num_errors, checked, stepCnt;
    logic             sawClear, badDir;  // monitor flags
    rx_lane_phase_deskew #(.LANES(LANES), .SHIFT_COUNT(STEPS))
    rx_lane_phase_deskew_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
        .rxResetDone(rxResetDone), .clkMgrLocked(clkMgrLocked),
        .psDone(psDone), .extBufClear(extBufClear),
        .multiLaneSel(multiLaneSel), .txAlignStart(txAlignStart),
        .txPhaseInitComplete(txPhaseInitComplete), .psEnQ(psEnQ),
        .psIncDecQ(psIncDecQ), .rxFifoBufferClearQ(clearQ),
        .deskewDoneQ(doneQ), .multiLaneModeQ(modeQ),
        .masterTxPhaseInitReqQ(masterReq),
        .slaveTxPhaseInitReqQ(slaveReq),
        .masterTxPhaseInitCompleteQ(masterCmp));
    phase_step_model phase_step_model_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .slowAck(slowAck),
        .psEn(psEnQ), .psDone(psDone), .overlapErr(overlapErr));
    // clock generator
    initial sys_clk = 1'b0;
    always #12.5 sys_clk = ~sys_clk;
    // count step requests, note direction and buffer clear
    always @(posedge sys_clk) begin
        if (psEnQ === 1'b1) stepCnt++;
        if (psEnQ === 1'b1 && psIncDecQ !== 1'b1) badDir = 1'b1;
        if (clearQ === 1'b1) sawClear = 1'b1;
    end
    task automatic check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    // raise all reset-done lines and follow one full adjustment
    task automatic run_adjust();
        int n;
        stepCnt = 0;
        sawClear = 1'b0;
        rxResetDone = '1;
        n = 0;
        while (!(doneQ === 1'b1 && sawClear) && n < 400) begin
            tick(1);
            n++;
        end
        tick(20);
        check(stepCnt == STEPS, "step count wrong");
        check(sawClear, "no buffer clear after steps");
        check(doneQ === 1'b1, "adjustment not finished");
        check(!badDir, "step direction wrong");
        check(overlapErr === 1'b0, "overlapping steps");
    endtask
    task automatic test_gating();
        stepCnt = 0;
        clkMgrLocked = 1'b1;
        rxResetDone = 4'h7;
        tick(30);
        check(stepCnt == 0, "step before all lanes done");
        rxResetDone = '0;
        clkMgrLocked = 1'b0;
        tick(5);
        rxResetDone = '1;
        tick(30);
        check(stepCnt == 0, "step while unlocked");
        rxResetDone = '0;
        clkMgrLocked = 1'b1;
        tick(10);
        $display("test_gating finished");
    endtask
    task automatic test_full();
        slowAck = 1'b0;
        run_adjust();
        $display("test_full finished");
    endtask
    task automatic test_retrain();
        int n;
        slowAck = 1'b1;
        rxResetDone = '0;
        tick(10);
        stepCnt = 0;
        rxResetDone = '1;
        n = 0;
        while (stepCnt < 1 && n < 50) begin
            tick(1);
            n++;
        end
        rxResetDone = '0;
        tick(12);
        run_adjust();
        $display("test_retrain finished");
    endtask
    task automatic test_ext_clear();
        int n;
        clkEn = 1'b0;
        extBufClear = 1'b1;
        tick(8);
        check(clearQ === 1'b0, "state moved while clock enable low");
        clkEn = 1'b1;
        n = 0;
        while (clearQ !== 1'b1 && n < 10) begin
            tick(1);
            n++;
        end
        check(clearQ === 1'b1, "external clear ignored");
        extBufClear = 1'b0;
        tick(10);
        $display("test_ext_clear finished");
    endtask
    task automatic test_tx_align();
        int ord[4] = '{2, 0, 3, 1};  // slave completes out of order
        check(modeQ === 1'b1, "multi-lane mode off");
        check(masterReq === 1'b0 && slaveReq === 4'h0, "early req");
        txAlignStart = 1'b1;
        tick(1);
        check(masterReq === 1'b1 && slaveReq === 4'hF, "req skew");
        txAlignStart = 1'b0;
        for (int i = 0; i < 4; i++) begin
            txPhaseInitComplete[ord[i]] = 1'b1;
            tick(4);
            check(masterCmp === (i == 3), "master complete wrong");
        end
        multiLaneSel = 1'b0;
        tick(1);
        check(modeQ === 1'b0, "multi-lane mode stuck on");
        multiLaneSel = 1'b1;
        tick(1);
        check(modeQ === 1'b1, "multi-lane mode not back");
        $display("test_tx_align finished");
    endtask
    task automatic results();
        $display("errors %0d of %0d checks", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // watchdog against a hung sequence
    initial begin
        #1000000;
        num_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        results();
    end
    initial begin
        {rst_n, clkMgrLocked, extBufClear, txAlignStart, slowAck} = '0;
        {rxResetDone, txPhaseInitComplete, badDir, sawClear} = '0;
        {num_errors, checked, stepCnt} = '0;
        multiLaneSel = 1'b1;
        clkEn = 1'b1;
        tick(4);
        check(psEnQ === 1'b0 && clearQ === 1'b0, "outputs not idle");
        rst_n = 1'b1;
        tick(4);
        test_gating();
        test_full();
        test_retrain();
        test_ext_clear();
        test_tx_align();
        results();
    end
endmodule
`default_nettype wire
